// [vdc_pkg.sv]
// shared constants for the vbi data capture block
package vdc_pkg;

    // register offsets
    localparam logic [7:0] VDC_REQ_ADDR = 8'h0a;
    localparam logic [7:0] VDC_STATUS_ADDR = 8'h10;
    localparam logic [7:0] VDC_CC_LOW_ADDR = 8'h12;
    localparam logic [7:0] VDC_CC_HIGH_ADDR = 8'h13;
    localparam logic [7:0] VDC_EXT_LOW_ADDR = 8'h14;
    localparam logic [7:0] VDC_EXT_HIGH_ADDR = 8'h15;
    localparam logic [7:0] VDC_CW_A_ADDR = 8'h16;
    localparam logic [7:0] VDC_CW_B_ADDR = 8'h17;

    // capture kinds, also the request bit positions
    localparam int VDC_KINDS = 3;
    localparam int VDC_CAPTION_BIT = 0;
    localparam int VDC_EXTENDED_BIT = 1;
    localparam int VDC_COPY_WS_BIT = 2;

    // done flags sit at status bits 7:5, lowest kind at bit 5
    localparam int VDC_DONE_LSB = 5;
    localparam int VDC_OTHER_STATUS_W = 5;

    // reset values
    localparam logic [VDC_KINDS-1:0] VDC_PENDING_RST = 3'h0;
    localparam logic [VDC_KINDS-1:0] VDC_DONE_RST = 3'h7;
    localparam logic [15:0] VDC_RESULT_RST = 16'h0000;
    localparam logic [7:0] VDC_BYTE_RST = 8'h00;

    // vbi line numbers
    localparam int VDC_LINE_W = 10;
    localparam logic [9:0] VDC_CC_LINE = 10'h015;
    localparam logic [9:0] VDC_EXT_LINE = 10'h11c;
    localparam logic [9:0] VDC_CGMS_LINE_A = 10'h014;
    localparam logic [9:0] VDC_CGMS_LINE_B = 10'h11b;
    localparam logic [9:0] VDC_WSS_LINE = 10'h017;

    // sliced word layout
    localparam int VDC_SLICE_W = 20;
    localparam int VDC_CGMS_PAYLOAD_W = 13;
    localparam int VDC_CGMS_CRC_DATA_W = 14;
    localparam int VDC_CGMS_CRC_W = 6;
    localparam logic [5:0] VDC_CRC_POLY = 6'h03;
    localparam logic [5:0] VDC_CRC_INIT = 6'h3f;

endpackage

// [vdc_vbi_capture.sv]
// Operation
// - request register resets zero; bits 0..2 arm caption, extended, copy/widescreen.
// - writing caption request bit arms a pending wait for caption line.
// - writing extended request bit arms a pending wait for extended line.
// - copy/widescreen request waits for copy data on 525, widescreen on 625.
// - completion flags sit at status bits 7, 6 and 5.
// - caption done sets once pending caption data is decoded.
// - extended done sets once pending extended data is decoded.
// - shared done at status bit 7 sets once copy/widescreen data decoded.
// - caption done reads one after reset, clears on caption request write.
// - extended done reads one after reset, clears on extended request write.
// - copy/widescreen done reads one after reset, clears on its request write.
// - 525 lines: caption line 21, extended 284, copy data 20 and 283.
// - widescreen decoded only on 625-line input, from line 23.
// - copy-management data is accepted only on 525-line input.
// - copy data check code is evaluated and its outcome stored.
// - copy payload delivered to the result registers is 13 bits.
// - caption result low byte at 0x12, high byte at 0x13.
// - extended result low byte at 0x14, high byte at 0x15.
// - copy payload bits 1..6 into 0x16 5:0, bits 7..13 into 0x17 7:1.
// - widescreen bits 0..7 into 0x17, bits 8..13 into 0x16 5:0.
// - results hold until a later completed decode of same kind.
// - copy and widescreen share one result pair, chosen by line standard.
`timescale 1ns/10ps
module vdc_vbi_capture (
    input wire logic sys_clk_i, // 50 MHz system clock
    input wire logic rst_b_i, // asynchronous reset, active low
    input wire logic reg_wr_i, // register write strobe
    input wire logic reg_rd_i, // register read strobe
    input wire logic [7:0] reg_addr_i, // register sub address
    input wire logic [7:0] reg_wdata_i, // register write data
    output logic [7:0] reg_rdata_o, // register read data, one cycle later
    output logic reg_rvalid_o, // read data valid pulse
    input wire logic slice_valid_i, // one sliced vbi line word ready
    input wire logic [vdc_pkg::VDC_LINE_W-1:0] slice_line_i, // line number of word
    input wire logic [vdc_pkg::VDC_SLICE_W-1:0] slice_data_i, // sliced bits, first at 0
    input wire logic line_625_i, // input is a 625-line system
    input wire logic [vdc_pkg::VDC_OTHER_STATUS_W-1:0] other_status_i // status bits 4:0
);
    import vdc_pkg::*;

    logic [VDC_KINDS-1:0] pending;
    logic [VDC_KINDS-1:0] done;
    logic [VDC_KINDS-1:0] hit;
    logic [VDC_KINDS-1:0] req_wr;
    logic [VDC_KINDS-1:0] take;
    logic [15:0] cc_result;
    logic [15:0] ext_result;
    logic [7:0] cw_a;
    logic [7:0] cw_b;
    logic [7:0] next_cw_a;
    logic [7:0] next_cw_b;
    logic crc_ok;
    logic [7:0] next_rdata;

    // serial check code over the first 14 copy bits, first bit shifted in first
    function automatic logic [5:0] vdc_crc_calc(input logic [VDC_CGMS_CRC_DATA_W-1:0] d);
        logic [5:0] c;
        logic fb;
        c = VDC_CRC_INIT;
        fb = 1'b0;
        for (int i = 0; i < VDC_CGMS_CRC_DATA_W; i++) begin
            fb = d[i] ^ c[5];
            c = {c[4:0], 1'b0} ^ (fb ? VDC_CRC_POLY : 6'h00);
        end
        return c;
    endfunction

    // true when a valid word sits on the wanted line; shared by every kind's match
    function automatic logic vdc_on_line(input logic valid,
            input logic [VDC_LINE_W-1:0] ln, input logic [VDC_LINE_W-1:0] want);
        return valid && (ln == want);
    endfunction

    // line match per kind; the standard gates which kinds may match at all
    always_comb begin
        hit[VDC_CAPTION_BIT] = !line_625_i &&
            vdc_on_line(slice_valid_i, slice_line_i, VDC_CC_LINE);
        hit[VDC_EXTENDED_BIT] = !line_625_i &&
            vdc_on_line(slice_valid_i, slice_line_i, VDC_EXT_LINE);
        if (line_625_i) begin
            hit[VDC_COPY_WS_BIT] = vdc_on_line(slice_valid_i, slice_line_i, VDC_WSS_LINE);
        end else begin
            hit[VDC_COPY_WS_BIT] = vdc_on_line(slice_valid_i, slice_line_i, VDC_CGMS_LINE_A) ||
                vdc_on_line(slice_valid_i, slice_line_i, VDC_CGMS_LINE_B);
        end
    end

    // request strobes and capture moments
    always_comb begin
        for (int k = 0; k < VDC_KINDS; k++) begin
            req_wr[k] = reg_wr_i && (reg_addr_i == VDC_REQ_ADDR) && reg_wdata_i[k];
            take[k] = pending[k] && hit[k];
        end
    end

    // pending wait per kind; a capture in the write cycle satisfies that write
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pending <= VDC_PENDING_RST;
        end else begin
            for (int k = 0; k < VDC_KINDS; k++) begin
                if (take[k]) begin
                    pending[k] <= 1'b0;
                end else if (req_wr[k]) begin
                    pending[k] <= 1'b1;
                end
            end
        end
    end

    // done flags; a capture beats a clearing request write
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done <= VDC_DONE_RST;
        end else begin
            for (int k = 0; k < VDC_KINDS; k++) begin
                if (take[k]) begin
                    done[k] <= 1'b1;
                end else if (req_wr[k]) begin
                    done[k] <= 1'b0;
                end
            end
        end
    end

    assign crc_ok = vdc_crc_calc(slice_data_i[VDC_CGMS_CRC_DATA_W-1:0]) ==
        {slice_data_i[14], slice_data_i[15], slice_data_i[16],
         slice_data_i[17], slice_data_i[18], slice_data_i[19]};

    // copy or widescreen byte layout, picked by the standard
    always_comb begin
        next_cw_a = VDC_BYTE_RST;
        next_cw_b = VDC_BYTE_RST;
        if (line_625_i) begin
            next_cw_b = slice_data_i[7:0];
            next_cw_a[5:0] = slice_data_i[13:8];
        end else begin
            for (int i = 0; i < 6; i++) begin
                next_cw_a[5-i] = slice_data_i[i];
            end
            for (int j = 0; j < VDC_CGMS_PAYLOAD_W - 6; j++) begin
                next_cw_b[7-j] = slice_data_i[6+j];
            end
            // check outcome in the last slot
            next_cw_b[0] = crc_ok;
        end
    end

    // caption and extended results; hold until next capture of that kind
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cc_result <= VDC_RESULT_RST;
            ext_result <= VDC_RESULT_RST;
        end else begin
            if (take[VDC_CAPTION_BIT]) begin
                cc_result <= slice_data_i[15:0];
            end
            if (take[VDC_EXTENDED_BIT]) begin
                ext_result <= slice_data_i[15:0];
            end
        end
    end

    // shared copy / widescreen pair
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cw_a <= VDC_BYTE_RST;
            cw_b <= VDC_BYTE_RST;
        end else if (take[VDC_COPY_WS_BIT]) begin
            cw_a <= next_cw_a;
            cw_b <= next_cw_b;
        end
    end

    // read mux; the request register is write only and reads zero
    always_comb begin
        case (reg_addr_i)
            VDC_STATUS_ADDR: next_rdata = {done, other_status_i};
            VDC_CC_LOW_ADDR: next_rdata = cc_result[7:0];
            VDC_CC_HIGH_ADDR: next_rdata = cc_result[15:8];
            VDC_EXT_LOW_ADDR: next_rdata = ext_result[7:0];
            VDC_EXT_HIGH_ADDR: next_rdata = ext_result[15:8];
            VDC_CW_A_ADDR: next_rdata = cw_a;
            VDC_CW_B_ADDR: next_rdata = cw_b;
            default: next_rdata = VDC_BYTE_RST;
        endcase
    end

    // registered read answer so the port comes straight from a flop
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= VDC_BYTE_RST;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    // state straight after reset; a request or read in the first cycle must find it
    // idle after reset
    reset_idle_a: assert property ($rose(rst_b_i) |-> pending == VDC_PENDING_RST)
        else $error("requests pending after reset");
    reset_done_a: assert property ($rose(rst_b_i) |-> done == VDC_DONE_RST)
        else $error("done flags not set after reset");

    // request writes and the flags they move
    // reserved bits ignored
    req_reserved_a: assert property (reg_wr_i && reg_addr_i == VDC_REQ_ADDR &&
        reg_wdata_i[2:0] == 3'h0 && !(|take) |=> pending == $past(pending) && done == $past(done))
        else $error("reserved request bits changed state");
    request_arms_a: assert property (req_wr[0] && !take[0] |=> pending[0] && !done[0])
        else $error("caption request did not arm");
    ext_arms_a: assert property (req_wr[1] && !take[1] |=> pending[1] && !done[1])
        else $error("extended request did not arm");
    cw_arms_a: assert property (req_wr[2] && !take[2] |=> pending[2] && !done[2])
        else $error("copy widescreen request did not arm");
    cc_done_set_a: assert property (take[0] |=> done[0] && !pending[0])
        else $error("caption done not set");
    ext_done_set_a: assert property (take[1] |=> done[1] && !pending[1])
        else $error("extended done not set");
    cw_done_set_a: assert property (take[2] |=> done[2] && !pending[2])
        else $error("copy widescreen done not set");
    cc_done_hold_a: assert property (done[0] && !req_wr[0] |=> done[0])
        else $error("caption done dropped without request");
    ext_done_hold_a: assert property (done[1] && !req_wr[1] |=> done[1])
        else $error("extended done dropped without request");
    cw_done_hold_a: assert property (done[2] && !req_wr[2] |=> done[2])
        else $error("copy widescreen done dropped without request");
    cc_one_shot_a: assert property (take[0] ##1 !req_wr[0] |=> !pending[0])
        else $error("caption pending repeated without request");
    one_shot_a: assert property (take[1] ##1 !req_wr[1] |=> !pending[1])
        else $error("pending repeated without request");
    cw_one_shot_a: assert property (take[2] ##1 !req_wr[2] |=> !pending[2])
        else $error("copy widescreen pending repeated without request");

    // line and standard selection; the refusals watch the pending flop, not the decode
    // caption kinds 525
    ext_standard_a: assert property (line_625_i |-> !hit[1] && !hit[0])
        else $error("caption kinds matched on 625 input");
    cc_625_a: assert property (line_625_i |=> !$rose(done[0]) && !$rose(done[1]))
        else $error("caption kinds captured on 625 input");
    cc_refuse_a: assert property (slice_valid_i && slice_line_i != VDC_CC_LINE &&
        pending[0] && !req_wr[0] |=> pending[0] && !done[0])
        else $error("caption taken from a wrong line");
    ws_refuse_a: assert property (slice_valid_i && !line_625_i &&
        slice_line_i == VDC_WSS_LINE && pending[2] && !req_wr[2] |=> pending[2] && !done[2])
        else $error("widescreen taken on 525 input");
    copy_refuse_a: assert property (slice_valid_i && line_625_i && pending[2] &&
        !req_wr[2] && (slice_line_i == VDC_CGMS_LINE_A || slice_line_i == VDC_CGMS_LINE_B)
        |=> pending[2] && !done[2])
        else $error("copy data taken on 625 input");

    // stored results and their layout
    // caption word stored
    cc_store_a: assert property (take[0] |=> cc_result == $past(slice_data_i[15:0]))
        else $error("caption result not stored");
    ext_store_a: assert property (take[1] |=> ext_result == $past(slice_data_i[15:0]))
        else $error("extended result not stored");
    copy_layout_a: assert property (take[2] && !line_625_i |=>
        cw_a[5] == $past(slice_data_i[0]) && cw_a[0] == $past(slice_data_i[5]) &&
        cw_b[7] == $past(slice_data_i[6]))
        else $error("copy layout wrong");
    payload_end_a: assert property (take[2] && !line_625_i |=>
        cw_b[1] == $past(slice_data_i[12]))
        else $error("copy payload end misplaced");
    wss_layout_a: assert property (take[2] && line_625_i |=>
        cw_b == $past(slice_data_i[7:0]) && cw_a[5:0] == $past(slice_data_i[13:8]))
        else $error("widescreen layout wrong");
    crc_store_a: assert property (take[2] && !line_625_i |=> cw_b[0] == $past(crc_ok))
        else $error("check outcome not stored");
    cw_reserved_a: assert property (cw_a[7:6] == 2'h0)
        else $error("reserved result bits set");
    cc_hold_a: assert property (!take[0] |=> $stable(cc_result))
        else $error("caption result changed without capture");
    ext_hold_a: assert property (!take[1] |=> $stable(ext_result))
        else $error("extended result changed without capture");
    cw_hold_a: assert property (!take[2] |=> $stable(cw_a) && $stable(cw_b))
        else $error("copy widescreen result changed without capture");

    // read path; the answer is one cycle late, so each check looks at the registered copy
    // done flags read
    status_read_a: assert property (reg_rd_i && reg_addr_i == VDC_STATUS_ADDR |=>
        reg_rvalid_o && reg_rdata_o[7:5] == $past(done))
        else $error("status read wrong");
    status_low_a: assert property (reg_rd_i && reg_addr_i == VDC_STATUS_ADDR |=>
        reg_rdata_o[4:0] == $past(other_status_i))
        else $error("status low bits wrong");
    req_read_a: assert property (reg_rd_i && reg_addr_i == VDC_REQ_ADDR |=>
        reg_rvalid_o && reg_rdata_o == VDC_BYTE_RST)
        else $error("request register read not zero");
    cc_low_read_a: assert property (reg_rd_i && reg_addr_i == VDC_CC_LOW_ADDR |=>
        reg_rdata_o == $past(cc_result[7:0]))
        else $error("caption low byte read wrong");
    cc_read_a: assert property (reg_rd_i && reg_addr_i == VDC_CC_HIGH_ADDR |=>
        reg_rdata_o == $past(cc_result[15:8]))
        else $error("caption high byte read wrong");
    ext_read_a: assert property (reg_rd_i && reg_addr_i == VDC_EXT_LOW_ADDR |=>
        reg_rdata_o == $past(ext_result[7:0]))
        else $error("extended low byte read wrong");
    ext_high_read_a: assert property (reg_rd_i && reg_addr_i == VDC_EXT_HIGH_ADDR |=>
        reg_rdata_o == $past(ext_result[15:8]))
        else $error("extended high byte read wrong");
    cw_a_read_a: assert property (reg_rd_i && reg_addr_i == VDC_CW_A_ADDR |=>
        reg_rdata_o == $past(cw_a))
        else $error("shared result first byte read wrong");
    cw_read_a: assert property (reg_rd_i && reg_addr_i == VDC_CW_B_ADDR |=>
        reg_rdata_o == $past(cw_b))
        else $error("shared result read wrong");
    read_hold_a: assert property (!reg_rd_i |=> !reg_rvalid_o && $stable(reg_rdata_o))
        else $error("read data moved without a read");
endmodule

// [vdc_vbi_capture_bench.sv]
`timescale 1ns/10ps
// single compare point so every mismatch is reported and counted the same way
`define CHK(what, exp, seen) begin \
    checks_done++; \
    if ((seen) !== (exp)) begin \
        num_errors++; \
        $display("wrong value %s expected %h seen %h", what, exp, seen); \
    end \
end
module vdc_vbi_capture_bench;
    import vdc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic slice_valid_i = 1'b0;
    logic [VDC_LINE_W-1:0] slice_line_i = 10'h000;
    logic [VDC_SLICE_W-1:0] slice_data_i = 20'h00000;
    logic line_625_i = 1'b0;
    logic [VDC_OTHER_STATUS_W-1:0] other_status_i = 5'h0a;
    int num_errors = 0;
    int checks_done = 0;

    vdc_vbi_capture dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .slice_valid_i(slice_valid_i),
        .slice_line_i(slice_line_i), .slice_data_i(slice_data_i), .line_625_i(line_625_i),
        .other_status_i(other_status_i));

    // 50 MHz clock
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    // all tasks start and end 2 ns after a rising edge, clear of the sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge sys_clk_i);
        #2;
        reg_wr_i = 1'b0;
    endtask

    // read valid stands one cycle only, so the answer is taken right after the strobe edge
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(posedge sys_clk_i);
        #2;
        reg_rd_i = 1'b0;
        `CHK("read valid", 1'b1, reg_rvalid_o)
        `CHK($sformatf("reg %h", a), exp, reg_rdata_o)
        // idle edge so a following read never drops and raises the strobe in one step
        @(posedge sys_clk_i);
        #2;
    endtask

    task automatic chk_status(input logic [2:0] done);
        chk_rd(8'h10, {done, other_status_i});
    endtask

    // one sliced line word, then one idle cycle so the capture lands
    task automatic line_word(input logic [9:0] ln, input logic [19:0] d, input logic l625);
        slice_valid_i = 1'b1;
        slice_line_i = ln;
        slice_data_i = d;
        line_625_i = l625;
        @(posedge sys_clk_i);
        #2;
        slice_valid_i = 1'b0;
        slice_data_i = ~d;
        @(posedge sys_clk_i);
        #2;
    endtask

    // builds a copy word with its check code, spoiled on request
    function automatic logic [19:0] cgms_word(input logic [13:0] b, input logic good);
        logic [5:0] c;
        logic fb;
        logic [19:0] w;
        c = VDC_CRC_INIT;
        for (int i = 0; i < 14; i++) begin
            fb = c[5] ^ b[i];
            c = {c[4:0], 1'b0} ^ (fb ? VDC_CRC_POLY : 6'h00);
        end
        if (!good) begin
            c = ~c;
        end
        w[13:0] = b;
        for (int k = 0; k < 6; k++) begin
            w[14+k] = c[5-k];
        end
        return w;
    endfunction

    task automatic cgms_case(input logic [9:0] ln, input logic [13:0] b, input logic good);
        logic [7:0] e16;
        logic [7:0] e17;
        e16 = 8'h00;
        for (int i = 0; i < 6; i++) e16[5-i] = b[i];
        for (int j = 0; j < 7; j++) e17[7-j] = b[6+j];
        e17[0] = good;
        wr(8'h0a, 8'h04);
        chk_status(3'h3);
        line_word(ln, cgms_word(b, good), 1'b0);
        chk_status(3'h7);
        chk_rd(8'h16, e16);
        chk_rd(8'h17, e17);
    endtask

    task automatic print_verdict;
        $display("checks done %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // the tests take about 112 cycles; 3000 means a hang
    initial begin
        #60000;
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge sys_clk_i);
        #2;
        rst_b_i = 1'b1;
        chk_status(3'h7);
        chk_rd(8'h0a, 8'h00);
        chk_rd(8'h12, 8'h00);
        chk_rd(8'h20, 8'h00);
        wr(8'h12, 8'hff);
        chk_rd(8'h12, 8'h00);
        wr(8'h0a, 8'hf8);
        chk_status(3'h7);
        $display("test reset and access done");
        wr(8'h0a, 8'h01);
        chk_status(3'h6);
        line_word(10'h015, 20'h5a3c5, 1'b1);
        line_word(10'h016, 20'h5a3c5, 1'b0);
        chk_status(3'h6);
        line_word(10'h015, 20'h5a3c5, 1'b0);
        chk_status(3'h7);
        chk_rd(8'h12, 8'hc5);
        chk_rd(8'h13, 8'ha3);
        line_word(10'h015, 20'h01234, 1'b0);
        chk_rd(8'h12, 8'hc5);
        $display("test caption done");
        other_status_i = 5'h15;
        wr(8'h0a, 8'h02);
        chk_status(3'h5);
        line_word(10'h015, 20'h77777, 1'b0);
        line_word(10'h11c, 20'hf9e87, 1'b0);
        chk_status(3'h7);
        chk_rd(8'h14, 8'h87);
        chk_rd(8'h15, 8'h9e);
        chk_rd(8'h13, 8'ha3);
        $display("test extended done");
        cgms_case(10'h014, 14'h2a5b, 1'b1);
        cgms_case(10'h11b, 14'h1c36, 1'b0);
        $display("test copy done");
        wr(8'h0a, 8'h04);
        line_word(10'h017, 20'h3a5c3, 1'b0);
        line_word(10'h014, 20'h3a5c3, 1'b1);
        chk_status(3'h3);
        line_word(10'h017, 20'h3a5c3, 1'b1);
        chk_status(3'h7);
        chk_rd(8'h17, 8'hc3);
        chk_rd(8'h16, 8'h25);
        chk_rd(8'h14, 8'h87);
        $display("test widescreen done");
        wr(8'h0a, 8'h07);
        chk_status(3'h0);
        line_word(10'h015, 20'h0beef, 1'b0);
        chk_status(3'h1);
        line_word(10'h11c, 20'h0cafe, 1'b0);
        chk_status(3'h3);
        chk_rd(8'h12, 8'hef);
        chk_rd(8'h15, 8'hca);
        $display("test all requests done");
        print_verdict();
    end
endmodule
